// ### core/cie_params.svh
// Offsets, field positions, reset values and timing counts of the interrupt entry block
`ifndef CIE_PARAMS_SVH
`define CIE_PARAMS_SVH

`define CIE_OFS_CTRL 8'h00
`define CIE_OFS_FLAGS1 8'h04
`define CIE_OFS_FLAGS2 8'h08
`define CIE_OFS_EN1 8'h0C
`define CIE_OFS_EN2 8'h10
`define CIE_OFS_EXTCFG 8'h14
`define CIE_OFS_STATE 8'h18
`define CIE_OFS_SHADOW 8'h20

`define CIE_B_GIE 7
`define CIE_B_PERIPHERAL_GROUP_ENABLE 6
`define CIE_B_TMR0IE 5
`define CIE_B_EXT_PIN_IRQ_ENABLE 4
`define CIE_B_IOCIE 3
`define CIE_B_TMR0IF 2
`define CIE_B_EXT_PIN_IRQ_FLAG 1
`define CIE_B_IOCIF 0
`define CIE_B_EDGE 0
`define CIE_B_OSF 7

`define CIE_RST_BYTE 8'h00
`define CIE_REG2_MASK 8'hEF
`define CIE_STATUS_KEEP 8'hE7
`define CIE_VECTOR 15'h0004

`define CIE_CLK_NS 100
`define CIE_TCY_NS 400
`define CIE_TCY_CLKS (`CIE_TCY_NS / `CIE_CLK_NS)
`define CIE_ENTRY_TCY 2

`define CIE_RESP_OKAY 2'h0
`define CIE_RESP_DECERR 2'h3

`endif

// ### core/cie_pkg.sv
// Types shared by the interrupt entry block
package cie_pkg;
  typedef enum logic [1:0] {
    ST_RUN,
    ST_ENTRY,
    ST_RETURN
  } cie_state_e;
  typedef logic [7:0] cie_byte_t;
  typedef logic [14:0] cie_pc_t;
endpackage

// ### core/cie_core.sv
// Core interrupt gather, entry, context shadow and return logic with AXI4-Lite registers
// Operation
// - Any reset leaves every interrupt enable, global one included, cleared.
// - Redirect needs global enable, own enable, and group enable for peripherals.
// - Event flags set on every event regardless of any enable.
// - Entry flushes prefetch, clears global enable, pushes PC, saves context, loads 0004h.
// - With global enable clear events latch; pending ones serviced when re-enabled.
// - Return pops address, restores shadow context and sets global enable.
// - Synchronous sources reach the vector in three or four instruction cycles.
// - Asynchronous sources reach the vector in three to five instruction cycles.
// - Latency does not depend on one- or two-cycle current instruction.
// - External flag settable during Q4 through Q1, sampled every Q1.
// - Wake branches to vector if global enable set, else continues after sleep.
// - Instruction after sleep always executes before any vector branch.
// - External pin edge triggered; select set means rising, clear means falling.
// - Active edge sets external flag; with both enables it redirects.
// - Entry saves W, STATUS less TO/PD, BANK_SELECT_REG, FSRs, PC high latch; return restores.
// - Shadows readable and writable by software; written values get restored.
// - Second flag and enable registers: bit 4 reads zero, bit 7 oscillator fail.
// - Global enable is bit 7 of control; 1 enables, 0 disables all.
//
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "cie_params.svh"

module cie_core #(
  parameter int ENTRY_TCY = `CIE_ENTRY_TCY
) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [7:0] i_awaddr,
  input wire logic [2:0] i_awprot,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [7:0] i_araddr,
  input wire logic [2:0] i_arprot,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  input wire logic i_ext_pin,
  input wire logic i_tmr0_evt,
  input wire logic i_ioc_any,
  input wire logic [7:0] i_periph1_evt,
  input wire logic [7:0] i_periph2_evt,
  input wire cie_pkg::cie_pc_t i_pc,
  input wire logic i_return_from_irq,
  input wire logic i_sleep,
  input wire logic i_instr_retire,
  input wire cie_pkg::cie_byte_t i_live_w,
  input wire cie_pkg::cie_byte_t i_live_status,
  input wire cie_pkg::cie_byte_t i_live_bsr,
  input wire cie_pkg::cie_byte_t i_live_fsr0l,
  input wire cie_pkg::cie_byte_t i_live_fsr0h,
  input wire cie_pkg::cie_byte_t i_live_fsr1l,
  input wire cie_pkg::cie_byte_t i_live_fsr1h,
  input wire cie_pkg::cie_byte_t i_live_pc_high_latch,
  output logic [1:0] o_q_phase,
  output logic o_flush,
  output logic o_push,
  output cie_pkg::cie_pc_t o_push_pc,
  output logic o_vector_load,
  output cie_pkg::cie_pc_t o_vector_pc,
  output logic o_pop,
  output logic o_restore,
  output logic o_wake,
  output logic o_gie,
  output cie_pkg::cie_byte_t o_ctx_w,
  output cie_pkg::cie_byte_t o_ctx_status,
  output cie_pkg::cie_byte_t o_ctx_bsr,
  output cie_pkg::cie_byte_t o_ctx_fsr0l,
  output cie_pkg::cie_byte_t o_ctx_fsr0h,
  output cie_pkg::cie_byte_t o_ctx_fsr1l,
  output cie_pkg::cie_byte_t o_ctx_fsr1h,
  output cie_pkg::cie_byte_t o_ctx_pc_high_latch
);
  import cie_pkg::*;

  localparam int NSHADOW = 8;

  // Register index of a byte address; 5'h1F marks an unmapped address
  function automatic logic [4:0] reg_index(input logic [7:0] addr);
    logic [4:0] idx;
    idx = addr[6:2];
    if (addr[1:0] != 2'h0 || addr[7] || idx == 5'h07 || idx > 5'h0F) begin
      idx = 5'h1F;
    end
    return idx;
  endfunction

  // Any flag paired with its enable
  function automatic logic any_pair(input logic [7:0] flg, input logic [7:0] ena);
    return |(flg & ena);
  endfunction

  logic [1:0] q_ff;
  logic [7:0] ctrl_ff;
  logic [7:0] flags1_ff;
  logic [7:0] flags2_ff;
  logic [7:0] en1_ff;
  logic [7:0] en2_ff;
  logic edge_sel_ff;
  logic pin_prev_ff;
  logic ext_pend_ff;
  cie_byte_t shadow_ff [NSHADOW];
  cie_byte_t live_ctx [NSHADOW];
  cie_state_e state_ff;
  logic [7:0] tcy_cnt_ff;
  logic wake_hold_ff;
  logic wake_ff;
  logic flush_ff;
  logic vector_ff;
  logic pop_ff;
  logic restore_ff;
  cie_pc_t push_pc_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;

  logic wr_fire;
  logic rd_fire;
  logic [4:0] wr_idx;
  logic [4:0] rd_idx;
  logic [7:0] wbyte;
  logic wr_byte_ok;
  logic ext_edge;
  logic ext_set;
  logic req_core;
  logic req_periph;
  logic irq_req;
  logic is_q1;
  logic take;
  logic [7:0] nxt_ctrl;
  logic [31:0] nxt_rdata;

  assign live_ctx[0] = i_live_w;
  assign live_ctx[1] = i_live_status & `CIE_STATUS_KEEP;
  assign live_ctx[2] = i_live_bsr;
  assign live_ctx[3] = i_live_fsr0l;
  assign live_ctx[4] = i_live_fsr0h;
  assign live_ctx[5] = i_live_fsr1l;
  assign live_ctx[6] = i_live_fsr1h;
  assign live_ctx[7] = i_live_pc_high_latch;

  // Register bus handshakes; both write channels are taken together
  assign wr_fire = i_awvalid & i_wvalid & ~bvalid_ff;
  assign o_awready = wr_fire;
  assign o_wready = wr_fire;
  assign rd_fire = i_arvalid & ~rvalid_ff;
  assign o_arready = ~rvalid_ff;
  assign wr_idx = reg_index(i_awaddr);
  assign rd_idx = reg_index(i_araddr);
  assign wbyte = i_wdata[7:0];
  // Registers are one byte wide, so only lane 0 carries a write
  assign wr_byte_ok = wr_fire & i_wstrb[0];

  // Quadrature phase: 0 is Q1, 3 is Q4, one instruction cycle per turn
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q_ff <= 2'h0;
    end else begin
      q_ff <= q_ff + 2'h1;
    end
  end
  assign is_q1 = (q_ff == 2'h0);

  // External pin edge; input is already synchronous to the core clock
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_prev_ff <= 1'b0;
    end else begin
      pin_prev_ff <= i_ext_pin;
    end
  end
  assign ext_edge = edge_sel_ff ? (i_ext_pin & ~pin_prev_ff)
                                : (~i_ext_pin & pin_prev_ff);

  // Edges seen in Q2/Q3 wait here until the Q4-Q1 set window opens
  assign ext_set = (ext_edge | ext_pend_ff) & (q_ff == 2'h3 || q_ff == 2'h0);
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ext_pend_ff <= 1'b0;
    end else if (ext_set) begin
      ext_pend_ff <= 1'b0;
    end else if (ext_edge) begin
      ext_pend_ff <= 1'b1;
    end
  end

  // Request gathering: single vector, no priority between sources
  assign req_core = (ctrl_ff[`CIE_B_TMR0IE] & ctrl_ff[`CIE_B_TMR0IF])
                  | (ctrl_ff[`CIE_B_EXT_PIN_IRQ_ENABLE] & ctrl_ff[`CIE_B_EXT_PIN_IRQ_FLAG])
                  | (ctrl_ff[`CIE_B_IOCIE] & ctrl_ff[`CIE_B_IOCIF]);
  assign req_periph = ctrl_ff[`CIE_B_PERIPHERAL_GROUP_ENABLE]
                    & (any_pair(flags1_ff, en1_ff)
                       | any_pair(flags2_ff, en2_ff & `CIE_REG2_MASK));
  assign irq_req = req_core | req_periph;

  // Requests are sampled only at Q1, so the current instruction length never matters
  assign take = is_q1 & (state_ff == ST_RUN) & ctrl_ff[`CIE_B_GIE] & irq_req
              & ~i_sleep & ~wake_hold_ff;

  // Control register: global and group enables, core sources, flags
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (wr_byte_ok && wr_idx == 5'(`CIE_OFS_CTRL >> 2)) begin
      nxt_ctrl = wbyte;
    end
    if (take) begin
      nxt_ctrl[`CIE_B_GIE] = 1'b0;
    end else if (i_return_from_irq && state_ff == ST_RUN) begin
      nxt_ctrl[`CIE_B_GIE] = 1'b1;
    end
    // Hardware set wins over a software clear in the same cycle
    if (i_tmr0_evt) begin
      nxt_ctrl[`CIE_B_TMR0IF] = 1'b1;
    end
    if (ext_set) begin
      nxt_ctrl[`CIE_B_EXT_PIN_IRQ_FLAG] = 1'b1;
    end
    nxt_ctrl[`CIE_B_IOCIF] = i_ioc_any;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl_ff <= `CIE_RST_BYTE;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // Peripheral flag registers; event set wins over a same-cycle write
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      flags1_ff <= `CIE_RST_BYTE;
      flags2_ff <= `CIE_RST_BYTE;
    end else begin
      flags1_ff <= ((wr_byte_ok && wr_idx == 5'(`CIE_OFS_FLAGS1 >> 2)) ? wbyte : flags1_ff)
                 | i_periph1_evt;
      flags2_ff <= (((wr_byte_ok && wr_idx == 5'(`CIE_OFS_FLAGS2 >> 2)) ? wbyte : flags2_ff)
                 | i_periph2_evt) & `CIE_REG2_MASK;
    end
  end

  // Peripheral enable registers and edge select
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      en1_ff <= `CIE_RST_BYTE;
      en2_ff <= `CIE_RST_BYTE;
      edge_sel_ff <= 1'b0;
    end else if (wr_byte_ok) begin
      if (wr_idx == 5'(`CIE_OFS_EN1 >> 2)) begin
        en1_ff <= wbyte;
      end
      if (wr_idx == 5'(`CIE_OFS_EN2 >> 2)) begin
        en2_ff <= wbyte & `CIE_REG2_MASK;
      end
      if (wr_idx == 5'(`CIE_OFS_EXTCFG >> 2)) begin
        edge_sel_ff <= wbyte[`CIE_B_EDGE];
      end
    end
  end

  // Shadow context: entry capture beats a software write in the same cycle
  for (genvar g = 0; g < NSHADOW; g++) begin : g_shadow
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        shadow_ff[g] <= `CIE_RST_BYTE;
      end else if (take) begin
        shadow_ff[g] <= live_ctx[g];
      end else if (wr_byte_ok && wr_idx == 5'((`CIE_OFS_SHADOW >> 2) + g)) begin
        shadow_ff[g] <= (g == 1) ? (wbyte & `CIE_STATUS_KEEP) : wbyte;
      end
    end
  end

  // Entry and return sequencer
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_ff <= ST_RUN;
      tcy_cnt_ff <= 8'h00;
    end else begin
      case (state_ff)
        ST_RUN: begin
          if (take) begin
            state_ff <= ST_ENTRY;
            tcy_cnt_ff <= 8'(ENTRY_TCY);
          end else if (i_return_from_irq) begin
            state_ff <= ST_RETURN;
          end
        end
        ST_ENTRY: begin
          // Fixed dead time keeps latency at 3-4 cycles synchronous, 3-5 asynchronous
          if (is_q1) begin
            if (tcy_cnt_ff == 8'h01) begin
              state_ff <= ST_RUN;
            end
            tcy_cnt_ff <= tcy_cnt_ff - 8'h01;
          end
        end
        ST_RETURN: begin
          state_ff <= ST_RUN;
        end
        default: begin
          state_ff <= ST_RUN;
        end
      endcase
    end
  end

  // Strobes to the core sequencer, all registered
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      flush_ff <= 1'b0;
      push_pc_ff <= 15'h0000;
      vector_ff <= 1'b0;
      pop_ff <= 1'b0;
      restore_ff <= 1'b0;
    end else begin
      flush_ff <= take;
      if (take) begin
        push_pc_ff <= i_pc;
      end
      vector_ff <= (state_ff == ST_ENTRY) & is_q1 & (tcy_cnt_ff == 8'h01);
      pop_ff <= (state_ff == ST_RUN) & i_return_from_irq & ~take;
      restore_ff <= (state_ff == ST_RUN) & i_return_from_irq & ~take;
    end
  end

  // Wake from sleep ignores global enable; one instruction must retire first
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wake_ff <= 1'b0;
      wake_hold_ff <= 1'b0;
    end else begin
      wake_ff <= i_sleep & irq_req;
      if (i_sleep & irq_req) begin
        wake_hold_ff <= 1'b1;
      end else if (i_instr_retire & ~i_sleep) begin
        wake_hold_ff <= 1'b0;
      end
    end
  end

  // Register bus write response
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= `CIE_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= (wr_idx == 5'h1F) ? `CIE_RESP_DECERR : `CIE_RESP_OKAY;
    end else if (i_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // Read data mux; flags read live so polling software sees fresh events
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    case (rd_idx)
      5'h00: nxt_rdata[7:0] = ctrl_ff;
      5'h01: nxt_rdata[7:0] = flags1_ff;
      5'h02: nxt_rdata[7:0] = flags2_ff;
      5'h03: nxt_rdata[7:0] = en1_ff;
      5'h04: nxt_rdata[7:0] = en2_ff;
      5'h05: nxt_rdata[`CIE_B_EDGE] = edge_sel_ff;
      5'h06: nxt_rdata[7:0] = {4'h0, wake_hold_ff, irq_req, state_ff};
      default: begin
        if (rd_idx >= 5'h08 && rd_idx <= 5'h0F) begin
          nxt_rdata[7:0] = shadow_ff[rd_idx[2:0]];
        end
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= `CIE_RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= nxt_rdata;
      rresp_ff <= (rd_idx == 5'h1F) ? `CIE_RESP_DECERR : `CIE_RESP_OKAY;
    end else if (i_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign o_bvalid = bvalid_ff;
  assign o_bresp = bresp_ff;
  assign o_rvalid = rvalid_ff;
  assign o_rdata = rdata_ff;
  assign o_rresp = rresp_ff;
  assign o_q_phase = q_ff;
  assign o_flush = flush_ff;
  assign o_push = flush_ff;
  assign o_push_pc = push_pc_ff;
  assign o_vector_load = vector_ff;
  assign o_vector_pc = `CIE_VECTOR;
  assign o_pop = pop_ff;
  assign o_restore = restore_ff;
  assign o_wake = wake_ff;
  assign o_gie = ctrl_ff[`CIE_B_GIE];
  assign o_ctx_w = shadow_ff[0];
  assign o_ctx_status = shadow_ff[1];
  assign o_ctx_bsr = shadow_ff[2];
  assign o_ctx_fsr0l = shadow_ff[3];
  assign o_ctx_fsr0h = shadow_ff[4];
  assign o_ctx_fsr1l = shadow_ff[5];
  assign o_ctx_fsr1h = shadow_ff[6];
  assign o_ctx_pc_high_latch = shadow_ff[7];

endmodule

`default_nettype wire

// ### test/cie_core_sva.sv
// Assertion checker for the interrupt entry block
`timescale 1ns/1ns
`default_nettype none
module cie_core_sva (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_return_from_irq,
  input wire logic i_sleep,
  input wire cie_pkg::cie_pc_t i_pc,
  input wire cie_pkg::cie_byte_t i_live_w,
  input wire cie_pkg::cie_byte_t i_live_status,
  input wire logic [1:0] o_q_phase,
  input wire logic o_flush,
  input wire logic o_push,
  input wire cie_pkg::cie_pc_t o_push_pc,
  input wire logic o_vector_load,
  input wire cie_pkg::cie_pc_t o_vector_pc,
  input wire logic o_pop,
  input wire logic o_restore,
  input wire logic o_wake,
  input wire logic o_gie,
  input wire cie_pkg::cie_byte_t o_ctx_w,
  input wire cie_pkg::cie_byte_t o_ctx_status
);
  import cie_pkg::*;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  sequence s_take; o_flush && o_push && !o_gie; endsequence
  sequence s_vec; ##8 o_vector_load && o_vector_pc == 15'h0004; endsequence
  property p_entry; o_flush |-> s_take; endproperty
  property p_vector; s_take |-> s_vec; endproperty
  property p_gate; !o_gie |=> !o_push; endproperty
  property p_q1; o_push |-> $past(o_q_phase) == 2'd0; endproperty
  property p_save; o_push |-> o_push_pc == $past(i_pc) && o_ctx_w == $past(i_live_w); endproperty
  property p_stat; o_push |-> o_ctx_status == ($past(i_live_status) & 8'hE7); endproperty
  property p_ret; o_pop |-> o_restore && o_gie && $past(i_return_from_irq); endproperty
  property p_rst; !$past(i_rst_b) |-> !o_gie; endproperty
  property p_wake; o_wake |-> $past(i_sleep) ##1 !o_push; endproperty
  a_entry: assert property (p_entry) else $error("entry pulse malformed");
  a_vector: assert property (p_vector) else $error("vector load late");
  a_gate: assert property (p_gate) else $error("entry with global off");
  a_q1: assert property (p_q1) else $error("entry off first phase");
  a_save: assert property (p_save) else $error("context not saved");
  a_stat: assert property (p_stat) else $error("status shadow wrong");
  a_ret: assert property (p_ret) else $error("return malformed");
  a_rst: assert property (p_rst) else $error("enabled out of reset");
  a_wake: assert property (p_wake) else $error("wake misbehaves");
endmodule
bind cie_core cie_core_sva cie_core_sva_u (.i_core_clk, .i_rst_b, .i_return_from_irq, .i_sleep, .i_pc,
  .i_live_w, .i_live_status, .o_q_phase, .o_flush, .o_push, .o_push_pc, .o_vector_load,
  .o_vector_pc, .o_pop, .o_restore, .o_wake, .o_gie, .o_ctx_w, .o_ctx_status);
`default_nettype wire

// ### test/cie_core_partner.sv
// Behavioural model of the processor sequencer around the interrupt entry block
`timescale 1ns/1ns
`default_nettype none
module cie_core_partner (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_ret_cmd,
  input wire logic [1:0] i_q_phase,
  input wire logic i_vector_load,
  input wire cie_pkg::cie_pc_t i_vector_pc,
  input wire logic i_pop,
  input wire cie_pkg::cie_pc_t i_push_pc,
  input wire logic i_restore,
  input wire cie_pkg::cie_byte_t i_ctx_w,
  output cie_pkg::cie_pc_t o_pc,
  output logic o_return_from_irq,
  output logic o_retire,
  output cie_pkg::cie_byte_t o_live_w
);
  import cie_pkg::*;
  // Live register keeps changing so a stale capture shows up
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pc <= 15'h0000;
      o_live_w <= 8'h5A;
      o_return_from_irq <= 1'b0;
      o_retire <= 1'b0;
    end else begin
      o_retire <= (i_q_phase == 2'd3);
      o_return_from_irq <= i_ret_cmd;
      if (i_vector_load) begin
        o_pc <= i_vector_pc;
      end else if (i_pop) begin
        o_pc <= i_push_pc;
      end else if (i_q_phase == 2'd3) begin
        o_pc <= o_pc + 15'h0001;
      end
      if (i_restore) begin
        o_live_w <= i_ctx_w;
      end else if (i_q_phase == 2'd3) begin
        o_live_w <= o_live_w + 8'h13;
      end
    end
  end
endmodule
`default_nettype wire

// ### test/cie_core_test.sv
// Self-checking testbench of the interrupt entry block
`timescale 1ns/1ns
`default_nettype none
`include "cie_params.svh"
module cie_core_test;
  import cie_pkg::*;
  logic i_core_clk, i_rst_b, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic i_ext_pin, i_tmr0_evt, i_sleep, ret_cmd, i_ioc_any;
  logic [7:0] i_awaddr, i_araddr, i_periph1_evt, i_periph2_evt, rd_v;
  logic [31:0] i_wdata;
  logic [1:0] rd_r, wr_r;
  int n_mismatch, cmp_count, n_push, n, p0;
  wire o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_push, o_vector_load;
  wire o_pop, o_restore, o_wake, o_gie, return_from_irq, retire;
  wire [1:0] o_bresp, o_rresp, o_q_phase;
  wire [31:0] o_rdata;
  wire [14:0] o_push_pc, o_vector_pc, pc;
  wire [7:0] o_ctx_w, lw, o_ctx_pc_high_latch;
  wire [7:0] o_ctx_status, o_ctx_bsr, o_ctx_fsr0l, o_ctx_fsr0h, o_ctx_fsr1l, o_ctx_fsr1h;
  cie_core #(.ENTRY_TCY(2)) dut_u (.i_core_clk, .i_rst_b, .i_awvalid, .o_awready, .i_awaddr,
    .i_awprot(3'h0), .i_wvalid, .o_wready, .i_wdata, .i_wstrb(4'hF), .o_bvalid, .i_bready,
    .o_bresp, .i_arvalid, .o_arready, .i_araddr, .i_arprot(3'h0), .o_rvalid, .i_rready,
    .o_rdata, .o_rresp, .i_ext_pin, .i_tmr0_evt, .i_ioc_any, .i_periph1_evt,
    .i_periph2_evt, .i_pc(pc), .i_return_from_irq(return_from_irq), .i_sleep, .i_instr_retire(retire),
    .i_live_w(lw), .i_live_status(lw ^ 8'hFF), .i_live_bsr(lw ^ 8'h11),
    .i_live_fsr0l(lw ^ 8'h22), .i_live_fsr0h(lw ^ 8'h33), .i_live_fsr1l(lw ^ 8'h44),
    .i_live_fsr1h(lw ^ 8'h55), .i_live_pc_high_latch(lw ^ 8'h66), .o_q_phase, .o_flush(), .o_push,
    .o_push_pc, .o_vector_load, .o_vector_pc, .o_pop, .o_restore, .o_wake, .o_gie, .o_ctx_w,
    .o_ctx_status, .o_ctx_bsr, .o_ctx_fsr0l, .o_ctx_fsr0h, .o_ctx_fsr1l,
    .o_ctx_fsr1h, .o_ctx_pc_high_latch);
  cie_core_partner partner_u (.i_core_clk, .i_rst_b, .i_ret_cmd(ret_cmd), .i_q_phase(o_q_phase),
    .i_vector_load(o_vector_load), .i_vector_pc(o_vector_pc), .i_pop(o_pop),
    .i_push_pc(o_push_pc), .i_restore(o_restore), .i_ctx_w(o_ctx_w), .o_pc(pc),
    .o_return_from_irq(return_from_irq), .o_retire(retire), .o_live_w(lw));
  always #50 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) if (o_push === 1'b1) n_push++;
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task test_done;
    $display("compares=%0d mismatches=%0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_awvalid <= 1'b1; i_awaddr <= a; i_wvalid <= 1'b1; i_wdata <= {24'h0, d}; i_bready <= 1'b1;
    @(posedge i_core_clk iff (o_awready && o_wready));
    i_awvalid <= 1'b0; i_wvalid <= 1'b0;
    @(posedge i_core_clk iff o_bvalid);
    i_bready <= 1'b0; wr_r = o_bresp;
  endtask
  task rd(input logic [7:0] a);
    @(posedge i_core_clk);
    i_arvalid <= 1'b1; i_araddr <= a; i_rready <= 1'b1;
    @(posedge i_core_clk iff o_arready);
    i_arvalid <= 1'b0;
    @(posedge i_core_clk iff o_rvalid);
    i_rready <= 1'b0; rd_v = o_rdata[7:0]; rd_r = o_rresp;
  endtask
  // Pulse timer and peripheral events for one cycle; wait_vec counts cycles until the vector is loaded
  task fire(input logic tm, input logic [7:0] p2);
    @(posedge i_core_clk);
    i_tmr0_evt <= tm; i_periph2_evt <= p2;
    @(posedge i_core_clk);
    i_tmr0_evt <= 1'b0; i_periph2_evt <= 8'h00;
  endtask
  task wait_vec;
    n = 0;
    while (o_vector_load !== 1'b1 && n < 40) begin @(negedge i_core_clk); n++; end
  endtask
  task ret;
    @(posedge i_core_clk); ret_cmd <= 1'b1;
    @(posedge i_core_clk); ret_cmd <= 1'b0;
    n = 0;
    while (o_pop !== 1'b1 && n < 10) begin @(negedge i_core_clk); n++; end
    chk(o_pop, 1'b1);
  endtask
  task s_regs;
    rd(`CIE_OFS_CTRL); chk(rd_v, 8'h00);
    @(posedge i_core_clk) i_ioc_any <= 1'b1;
    wr(`CIE_OFS_CTRL, 8'h00); rd(`CIE_OFS_CTRL); chk(rd_v, 8'h01);
    @(posedge i_core_clk) i_ioc_any <= 1'b0;
    rd(`CIE_OFS_CTRL); chk(rd_v, 8'h00);
    @(posedge i_core_clk) i_periph1_evt <= 8'h81;
    @(posedge i_core_clk) i_periph1_evt <= 8'h00;
    rd(`CIE_OFS_FLAGS1); chk(rd_v, 8'h81);
    wr(`CIE_OFS_FLAGS1, 8'h00); chk(wr_r, `CIE_RESP_OKAY);
    wr(`CIE_OFS_EN2, 8'hFF); rd(`CIE_OFS_EN2); chk(rd_v, 8'hEF);
    rd(8'h1C); chk({rd_r, rd_v}, {2'h3, 8'h00});
    wr(8'h1C, 8'hFF); chk(wr_r, `CIE_RESP_DECERR);
    wr(`CIE_OFS_EN2, 8'h00); p0 = n_push;
    fire(1'b0, 8'hFF); rd(`CIE_OFS_FLAGS2); chk(rd_v, 8'hEF);
    chk(n_push, p0);
    wr(`CIE_OFS_FLAGS2, 8'h00); rd(`CIE_OFS_FLAGS2); chk(rd_v, 8'h00);
  endtask
  task s_entry;
    wr(`CIE_OFS_EN2, 8'h80); wr(`CIE_OFS_CTRL, 8'h80); p0 = n_push;
    fire(1'b0, 8'h80); repeat (20) @(posedge i_core_clk);
    chk(n_push, p0);
    wr(`CIE_OFS_CTRL, 8'hC0); wait_vec; chk(n_push, p0 + 1);
    chk({o_ctx_bsr, o_ctx_fsr0l, o_ctx_fsr0h} ^ {3{o_ctx_w}}, 24'h112233);
    chk({o_ctx_fsr1l, o_ctx_fsr1h, o_ctx_pc_high_latch} ^ {3{o_ctx_w}}, 24'h445566);
    chk(o_ctx_status, ~o_ctx_w & `CIE_STATUS_KEEP);
    rd(`CIE_OFS_CTRL); chk(rd_v, 8'h40);
    wr(`CIE_OFS_FLAGS2, 8'h00);
    wr(`CIE_OFS_SHADOW, 8'hA5); rd(`CIE_OFS_SHADOW); chk(rd_v, 8'hA5);
    ret; @(negedge i_core_clk);
    chk({o_gie, lw}, {1'b1, 8'hA5});
  endtask
  task s_latency;
    wr(`CIE_OFS_CTRL, 8'hA0); fire(1'b1, 8'h00); wait_vec;
    chk(n <= 17, 1'b1);
    wr(`CIE_OFS_CTRL, 8'h20); ret;
  endtask
  task s_ext;
    wr(`CIE_OFS_CTRL, 8'h00); wr(`CIE_OFS_EXTCFG, 8'h01);
    @(posedge i_core_clk) i_ext_pin <= 1'b1; repeat (8) @(posedge i_core_clk);
    rd(`CIE_OFS_CTRL); chk(rd_v, 8'h02);
    wr(`CIE_OFS_CTRL, 8'h00);
    @(posedge i_core_clk) i_ext_pin <= 1'b0; repeat (8) @(posedge i_core_clk);
    rd(`CIE_OFS_CTRL); chk(rd_v, 8'h00);
    wr(`CIE_OFS_EXTCFG, 8'h00);
    @(posedge i_core_clk) i_ext_pin <= 1'b1; repeat (8) @(posedge i_core_clk);
    @(posedge i_core_clk) i_ext_pin <= 1'b0; repeat (8) @(posedge i_core_clk);
    rd(`CIE_OFS_CTRL); chk(rd_v, 8'h02);
  endtask
  task s_sleep;
    wr(`CIE_OFS_CTRL, 8'h12); p0 = n_push;
    @(posedge i_core_clk) i_sleep <= 1'b1; repeat (3) @(posedge i_core_clk);
    @(negedge i_core_clk); chk({o_wake, o_gie}, 2'b10);
    @(posedge i_core_clk) i_sleep <= 1'b0; repeat (12) @(posedge i_core_clk);
    chk(n_push, p0);
    wr(`CIE_OFS_CTRL, 8'h10); @(posedge i_core_clk) i_sleep <= 1'b1;
    wr(`CIE_OFS_CTRL, 8'h92); repeat (8) @(posedge i_core_clk);
    chk(n_push, p0);
    @(posedge i_core_clk) i_sleep <= 1'b0; wait_vec;
    chk({o_vector_load, n_push == p0 + 1}, 2'b11);
  endtask
  initial begin
    {i_core_clk, i_rst_b, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = '0;
    {i_ext_pin, i_tmr0_evt, i_sleep, ret_cmd, i_awaddr, i_araddr, i_periph2_evt} = '0;
    {i_ioc_any, i_periph1_evt} = '0;
    i_wdata = 32'h0; n_mismatch = 0; cmp_count = 0; n_push = 0;
    repeat (20) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    s_regs; s_entry; s_latency; s_ext; s_sleep;
    test_done;
  end
  // Whole run is well under a thousand cycles
  initial begin
    #(20000 * 100);
    n_mismatch++;
    test_done;
  end
endmodule
`default_nettype wire
